// [src/mmd_decoder.sv]
// Address generation and memory-space decoder for the unified 24-bit memory map
`timescale 1ns/1ns

module mmd_decoder (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  page_wr,
    input  wire logic [1:0]            page_idx,
    input  wire logic [7:0]            page_val,
    input  wire logic                  bound_wr,
    input  wire logic [1:0]            bound_idx,
    input  wire logic [7:0]            bound_val,
    input  wire logic                  bank_cfg_wr,
    input  wire logic [1:0]            bank_cfg_idx,
    input  wire logic [3:0]            bank_cfg_val,
    input  wire logic                  space_cfg_wr,
    input  wire logic [1:0]            space_cfg_idx,
    input  wire logic [11:0]           space_cfg_val,
    input  wire logic                  rom_protect,
    input  wire logic                  peripheral_boot,
    input  wire logic                  req_valid,
    input  wire mmd_pkg::mmd_kind_t    req_kind,
    input  wire logic [15:0]           req_index,
    input  wire logic [15:0]           req_offset,
    input  wire logic [23:0]           req_imm,
    input  wire logic [9:0]            req_io_imm,
    input  wire logic                  req_emu,
    input  wire logic [7:0]            wr_data_hi,
    input  wire logic                  wr_drive,
    input  wire logic [7:0]            gpio_out,
    input  wire logic [7:0]            gpio_dir,
    input  wire logic [7:0]            mf_pin_i,
    output logic                       acc_valid_reg,
    output logic [23:0]                addr_reg,
    output logic [17:0]                io_addr_reg,
    output logic [23:0]                pc_reg,
    output logic [1:0]                 ram_block_sel_reg,
    output logic                       rom_sel_reg,
    output logic                       boot_rom_sel_reg,
    output logic                       onchip_io_sel_reg,
    output logic                       emu_refused_reg,
    output logic [3:0]                 bank_select_outputs_n_reg,
    output logic                       io_space_select_n_reg,
    output logic                       boot_space_select_n_reg,
    output logic [2:0]                 rd_wait_reg,
    output logic [2:0]                 wr_wait_reg,
    output logic                       wait_mode_reg,
    output logic [1:0]                 clk_div_reg,
    output logic                       hold_ext_reg,
    output logic                       strobe_pol_reg,
    output logic                       bus_wide_reg,
    output logic [7:0]                 mf_pin_o_reg,
    output logic [7:0]                 mf_pin_oe_reg,
    output logic [7:0]                 data_hi_in_reg,
    output logic [7:0]                 gpio_in_reg,
    output logic                       booting_peripheral_reg
);

    // ************************************************************
    // Configuration state
    // ************************************************************
    logic [7:0]  data_page_register [2];
    logic [7:0]  jump_page_register, io_page_register;
    logic [7:0]  bank_start [4];
    logic [3:0]  bank_cfg [4];
    logic [11:0] space_cfg [3];
    logic [7:0]  mf_meta, mf_sync;
    logic        periph_boot_meta, periph_boot_sync;

    // ************************************************************
    // Decode signals
    // ************************************************************
    logic [23:0] addr_next;
    logic [17:0] io_addr_next;
    logic [7:0]  page, io_page;
    logic        is_mem, in_ram, in_boot_rom, in_rom, refuse;
    logic [1:0]  bank_next, space_next;
    logic        ext_hit, io_hit, boot_hit;
    logic [11:0] cfg_sel;

    // Page register writes
    // Data, jump and I/O page registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_page_register[0] <= 8'h00;
            data_page_register[1] <= 8'h00;
            jump_page_register    <= 8'h00;
            io_page_register      <= 8'h00;
        end else if (page_wr) begin
            unique case (page_idx)
                mmd_pkg::PG_DATA0: data_page_register[0] <= page_val;
                mmd_pkg::PG_DATA1: data_page_register[1] <= page_val;
                mmd_pkg::PG_JUMP:  jump_page_register    <= page_val;
                mmd_pkg::PG_IO:    io_page_register      <= page_val;
            endcase
        end
    end

    // Bank boundaries; bank 0 always starts right after page 0
    // Reset page ranges
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bank_start[0] <= 8'h01;
            bank_start[1] <= mmd_pkg::BANK1_START_RST;
            bank_start[2] <= mmd_pkg::BANK2_START_RST;
            bank_start[3] <= mmd_pkg::BANK3_START_RST;
        end else if (bound_wr && (bound_idx != 2'h0)) begin
            bank_start[bound_idx] <= bound_val;
        end
    end

    // Per-bank wait count [2:0] and completion mode [3]
    // Independent bank waits
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bank_cfg <= '{default: mmd_pkg::BANK_CFG_RST};
        end else if (bank_cfg_wr) begin
            bank_cfg[bank_cfg_idx] <= bank_cfg_val;
        end
    end

    // One configuration word per off-chip space; slowest timing at reset
    // Separate space config
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            space_cfg <= '{default: mmd_pkg::CFG_RST};
        end else if (space_cfg_wr && (space_cfg_idx != 2'h3)) begin
            space_cfg[space_cfg_idx] <= space_cfg_val;
        end
    end

    // ************************************************************
    // Synchronisers for pins
    // ************************************************************
    // Two stages before anything reads the pin levels
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mf_meta          <= 8'h00;
            mf_sync          <= 8'h00;
            periph_boot_meta <= 1'b0;
            periph_boot_sync <= 1'b0;
        end else begin
            mf_meta          <= mf_pin_i;
            mf_sync          <= mf_meta;
            periph_boot_meta <= peripheral_boot;
            periph_boot_sync <= periph_boot_meta;
        end
    end

    // ************************************************************
    // Address generation
    // ************************************************************
    // Form the 24-bit or 18-bit address for each access kind
    always_comb begin
        addr_next    = 24'h000000;
        io_addr_next = 18'h00000;
        unique case (req_kind)
            mmd_pkg::MMD_DAG0:         addr_next = {data_page_register[0], req_index};
            mmd_pkg::MMD_DAG1:         addr_next = {data_page_register[1], req_index};
            mmd_pkg::MMD_SEQ_REL:      addr_next = 24'(pc_reg + {{8{req_offset[15]}}, req_offset});
            mmd_pkg::MMD_SEQ_DIRECT:   addr_next = req_imm;
            mmd_pkg::MMD_SEQ_INDIRECT: addr_next = {jump_page_register, req_index};
            mmd_pkg::MMD_IO:           io_addr_next = {io_page_register, req_io_imm};
            mmd_pkg::MMD_BOOT:         addr_next = req_imm;
            mmd_pkg::MMD_FETCH:        addr_next = pc_reg;
        endcase
    end

    // Memory-map decode of the formed address
    // Page is the upper eight bits
    assign page    = addr_next[23:16];
    assign io_page = io_addr_next[17:10];
    assign is_mem  = (req_kind != mmd_pkg::MMD_IO) && (req_kind != mmd_pkg::MMD_BOOT);
    assign in_ram  = is_mem && (page == mmd_pkg::PAGE_RAM);
    // Boot ROM at top of page 255
    assign in_boot_rom = is_mem && (page == mmd_pkg::PAGE_TOP) && (addr_next[15:10] == mmd_pkg::BOOT_ROM_TAG);
    assign in_rom  = is_mem && (page == mmd_pkg::PAGE_ROM) && (addr_next[15:14] == mmd_pkg::ROM_TAG);
    // Emulator kept out of ROM when protected
    assign refuse  = req_emu && rom_protect && (in_rom || in_boot_rom);
    assign ext_hit  = is_mem && (page != mmd_pkg::PAGE_RAM) && (page != mmd_pkg::PAGE_TOP);
    assign io_hit   = (req_kind == mmd_pkg::MMD_IO) && (io_page >= mmd_pkg::IO_ONCHIP_PAGES);
    // Boot space limited to 254 pages
    assign boot_hit = (req_kind == mmd_pkg::MMD_BOOT) && (req_imm[23:16] < mmd_pkg::BOOT_PAGES);

    // Highest bank whose start is not above the page wins, so exactly one matches
    // Boundary compare
    always_comb begin
        bank_next = 2'h0;
        if (page >= bank_start[3]) begin
            bank_next = 2'h3;
        end else if (page >= bank_start[2]) begin
            bank_next = 2'h2;
        end else if (page >= bank_start[1]) begin
            bank_next = 2'h1;
        end
    end

    // Choose which space configuration the access runs under
    assign space_next = (req_kind == mmd_pkg::MMD_IO)   ? mmd_pkg::SPACE_IO   :
                        (req_kind == mmd_pkg::MMD_BOOT) ? mmd_pkg::SPACE_BOOT : mmd_pkg::SPACE_EXT;
    assign cfg_sel = space_cfg[space_next];

    // ************************************************************
    // Program counter
    // ************************************************************
    // Fetch always starts in boot ROM; peripheral boot is carried out from there
    // Reset fetch address
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pc_reg <= mmd_pkg::BOOT_ROM_BASE;
        end else if (req_valid) begin
            unique case (req_kind)
                mmd_pkg::MMD_SEQ_REL, mmd_pkg::MMD_SEQ_DIRECT, mmd_pkg::MMD_SEQ_INDIRECT: pc_reg <= addr_next;
                mmd_pkg::MMD_FETCH:        pc_reg <= 24'(pc_reg + 24'h000001);
                default:                   pc_reg <= pc_reg;
            endcase
        end
    end

    // Boot-strap level followed every cycle from the synchroniser, shown to the boot ROM code
    // Peripheral boot flag
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            booting_peripheral_reg <= 1'b0;
        end else begin
            booting_peripheral_reg <= periph_boot_sync;
        end
    end

    // ************************************************************
    // Registered access outputs
    // ************************************************************
    // Address and on-chip selects, one cycle after the request
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            acc_valid_reg     <= 1'b0;
            addr_reg          <= 24'h000000;
            io_addr_reg       <= 18'h00000;
            ram_block_sel_reg <= 2'h0;
            rom_sel_reg       <= 1'b0;
            boot_rom_sel_reg  <= 1'b0;
            onchip_io_sel_reg <= 1'b0;
            emu_refused_reg   <= 1'b0;
        end else begin
            acc_valid_reg     <= req_valid;
            addr_reg          <= addr_next;
            io_addr_reg       <= io_addr_next;
            // Block picked by address bit 15
            ram_block_sel_reg <= (req_valid && in_ram) ? (addr_next[mmd_pkg::RAM_BLK_BIT] ? 2'h2 : 2'h1) : 2'h0;
            rom_sel_reg       <= req_valid && in_rom && !refuse;
            boot_rom_sel_reg  <= req_valid && in_boot_rom && !refuse;
            emu_refused_reg   <= req_valid && refuse;
            onchip_io_sel_reg <= req_valid && (req_kind == mmd_pkg::MMD_IO) && !io_hit;
        end
    end

    // Off-chip selects are active low; idle high
    // One-hot bank select
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bank_select_outputs_n_reg <= 4'hF;
            io_space_select_n_reg     <= 1'b1;
            boot_space_select_n_reg   <= 1'b1;
        end else begin
            bank_select_outputs_n_reg <= (req_valid && ext_hit) ? ~(4'h1 << bank_next) : 4'hF;
            io_space_select_n_reg     <= !(req_valid && io_hit);
            boot_space_select_n_reg   <= !(req_valid && boot_hit);
        end
    end

    // Timing for the access; a bank's own wait and mode override the space word
    // Bank wait applied
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_wait_reg    <= 3'h7;
            wr_wait_reg    <= 3'h7;
            wait_mode_reg  <= 1'b1;
            clk_div_reg    <= 2'h3;
            hold_ext_reg   <= 1'b1;
            strobe_pol_reg <= 1'b1;
            bus_wide_reg   <= 1'b1;
        end else if (req_valid) begin
            if (ext_hit) begin
                rd_wait_reg   <= bank_cfg[bank_next][2:0];
                wr_wait_reg   <= bank_cfg[bank_next][2:0];
                wait_mode_reg <= bank_cfg[bank_next][3];
            end else begin
                rd_wait_reg   <= cfg_sel[mmd_pkg::CFG_RDW_LSB +: 3];
                wr_wait_reg   <= cfg_sel[mmd_pkg::CFG_WRW_LSB +: 3];
                wait_mode_reg <= cfg_sel[mmd_pkg::CFG_MODE_BIT];
            end
            clk_div_reg    <= cfg_sel[mmd_pkg::CFG_DIV_LSB +: 2];
            hold_ext_reg   <= cfg_sel[mmd_pkg::CFG_HOLD_BIT];
            strobe_pol_reg <= cfg_sel[mmd_pkg::CFG_POL_BIT];
            // 8 or 16 bit per space
            bus_wide_reg   <= cfg_sel[mmd_pkg::CFG_WIDE_BIT];
        end
    end

    // ************************************************************
    // Multifunction pins
    // ************************************************************
    // Width of the external space decides the pin role, so the role
    // does not flip between accesses to differently configured spaces
    // Upper byte or GPIO
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mf_pin_o_reg   <= 8'h00;
            mf_pin_oe_reg  <= 8'h00;
            data_hi_in_reg <= 8'h00;
            gpio_in_reg    <= 8'h00;
        end else if (space_cfg[mmd_pkg::SPACE_EXT][mmd_pkg::CFG_WIDE_BIT]) begin
            mf_pin_o_reg   <= wr_data_hi;
            mf_pin_oe_reg  <= wr_drive ? 8'hFF : 8'h00;
            data_hi_in_reg <= mf_sync;
            gpio_in_reg    <= 8'h00;
        end else begin
            mf_pin_o_reg   <= gpio_out;
            mf_pin_oe_reg  <= gpio_dir;
            data_hi_in_reg <= 8'h00;
            gpio_in_reg    <= mf_sync;
        end
    end

endmodule : mmd_decoder

// [src/mmd_pkg.sv]
// Constants, field layouts and access kinds of the memory map decoder
package mmd_pkg;

    // ************************************************************
    // Address geometry
    // ************************************************************
    localparam int          ADDR_W          = 24;
    localparam int          PAGE_W          = 8;
    localparam int          OFFS_W          = 16;
    localparam int          IO_ADDR_W       = 18;
    localparam int          IO_IMM_W        = 10;
    localparam logic [7:0]  PAGE_RAM        = 8'h00;
    localparam logic [7:0]  PAGE_TOP        = 8'hFF;
    localparam logic [7:0]  PAGE_ROM        = 8'hFF;
    localparam logic [5:0]  BOOT_ROM_TAG    = 6'h3F;
    localparam logic [1:0]  ROM_TAG         = 2'h0;
    localparam int          RAM_BLK_BIT     = 15;
    localparam logic [7:0]  IO_ONCHIP_PAGES = 8'h20;
    localparam logic [7:0]  BOOT_PAGES      = 8'hFE;
    localparam logic [23:0] BOOT_ROM_BASE   = 24'hFFFC00;

    // ************************************************************
    // Bank page boundaries after reset (first page of banks 1..3)
    // ************************************************************
    localparam logic [7:0]  BANK1_START_RST = 8'h40;
    localparam logic [7:0]  BANK2_START_RST = 8'h80;
    localparam logic [7:0]  BANK3_START_RST = 8'hC0;

    // ************************************************************
    // Space configuration word fields and reset values
    // ************************************************************
    localparam int          CFG_W           = 12;
    localparam int          CFG_RDW_LSB     = 0;
    localparam int          CFG_WRW_LSB     = 3;
    localparam int          CFG_MODE_BIT    = 6;
    localparam int          CFG_DIV_LSB     = 7;
    localparam int          CFG_HOLD_BIT    = 9;
    localparam int          CFG_POL_BIT     = 10;
    localparam int          CFG_WIDE_BIT    = 11;
    localparam logic [11:0] CFG_RST         = 12'hFFF;
    localparam int          BANK_CFG_W      = 4;
    localparam logic [3:0]  BANK_CFG_RST    = 4'hF;

    // Space indices for the configuration port
    localparam logic [1:0]  SPACE_EXT       = 2'h0;
    localparam logic [1:0]  SPACE_IO        = 2'h1;
    localparam logic [1:0]  SPACE_BOOT      = 2'h2;

    // Page register indices
    localparam logic [1:0]  PG_DATA0        = 2'h0;
    localparam logic [1:0]  PG_DATA1        = 2'h1;
    localparam logic [1:0]  PG_JUMP         = 2'h2;
    localparam logic [1:0]  PG_IO           = 2'h3;

    // Kind of access presented by the core
    typedef enum logic [2:0] {
        MMD_DAG0,
        MMD_DAG1,
        MMD_SEQ_REL,
        MMD_SEQ_DIRECT,
        MMD_SEQ_INDIRECT,
        MMD_IO,
        MMD_BOOT,
        MMD_FETCH
    } mmd_kind_t;

endpackage : mmd_pkg

// [verification/mmd_chk.sv]
// Port checker for the memory map decoder
`timescale 1ns/1ns
module mmd_chk (
    input wire logic               mclk,
    input wire logic               resetn,
    input wire logic               req_valid,
    input wire mmd_pkg::mmd_kind_t req_kind,
    input wire logic [23:0]        req_imm,
    input wire logic [9:0]         req_io_imm,
    input wire logic               req_emu,
    input wire logic               rom_protect,
    input wire logic               acc_valid_reg,
    input wire logic [23:0]        addr_reg,
    input wire logic [17:0]        io_addr_reg,
    input wire logic [1:0]         ram_block_sel_reg,
    input wire logic               rom_sel_reg,
    input wire logic               boot_rom_sel_reg,
    input wire logic               onchip_io_sel_reg,
    input wire logic               emu_refused_reg,
    input wire logic [3:0]         bank_select_outputs_n_reg,
    input wire logic               io_space_select_n_reg,
    input wire logic               boot_space_select_n_reg
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // All off-chip selects parked high
    wire ext_idle = &bank_select_outputs_n_reg & io_space_select_n_reg & boot_space_select_n_reg;
    answer_lat_a: assert property (req_valid |=> acc_valid_reg) else $error("access not answered");
    sel_pulse_a: assert property (!acc_valid_reg |-> ext_idle) else $error("select without access");
    one_bank_a: assert property ($countones(~bank_select_outputs_n_reg) <= 1) else $error("two banks");
    ram_block_a: assert property (|ram_block_sel_reg |-> addr_reg[23:16] == 8'h00 && ext_idle
        && ram_block_sel_reg == (addr_reg[15] ? 2'b10 : 2'b01)) else $error("bad ram select");
    io_split_a: assert property (req_valid && req_kind == mmd_pkg::MMD_IO |=>
        onchip_io_sel_reg == (io_addr_reg[17:10] < 8'h20) && io_space_select_n_reg == onchip_io_sel_reg)
        else $error("bad io split");
    io_addr_a: assert property (req_valid && req_kind == mmd_pkg::MMD_IO |=>
        io_addr_reg[9:0] == $past(req_io_imm)) else $error("bad io offset");
    boot_sel_a: assert property (req_valid && req_kind == mmd_pkg::MMD_BOOT && req_imm[23:16] < 8'hFE
        |=> !boot_space_select_n_reg && &bank_select_outputs_n_reg) else $error("boot select missing");
    emu_refuse_a: assert property (req_valid && req_emu && rom_protect && req_kind != mmd_pkg::MMD_IO
        && req_kind != mmd_pkg::MMD_BOOT |=> emu_refused_reg == (addr_reg[23:16] == 8'hFF
        && (addr_reg[15:14] == 2'h0 || addr_reg[15:10] == 6'h3F)) && !rom_sel_reg && !boot_rom_sel_reg)
        else $error("refused access selected rom");
endmodule : mmd_chk

// [verification/mmd_decoder_tb.sv]
// Directed bench for the memory map decoder
`timescale 1ns/1ns
module mmd_decoder_tb;
    logic mclk = 0, resetn = 0, page_wr = 0, bound_wr = 0, bank_cfg_wr = 0, space_cfg_wr = 0;
    logic rom_protect = 0, peripheral_boot = 0, req_valid = 0, req_emu = 0, wr_drive = 0;
    logic [1:0] page_idx = 0, bound_idx = 0, bank_cfg_idx = 0, space_cfg_idx = 0;
    logic [7:0] page_val = 0, bound_val = 0, wr_data_hi = 0, gpio_out = 0, gpio_dir = 0, mf_pin_i, p;
    logic [3:0] bank_cfg_val = 0;
    logic [11:0] space_cfg_val = 0;
    mmd_pkg::mmd_kind_t req_kind = mmd_pkg::MMD_DAG0;
    logic [15:0] req_index = 0, req_offset = 0;
    logic [23:0] req_imm = 0, addr_reg, pc_reg;
    logic [9:0] req_io_imm = 0;
    logic acc_valid_reg, rom_sel_reg, boot_rom_sel_reg, onchip_io_sel_reg, emu_refused_reg;
    logic io_space_select_n_reg, boot_space_select_n_reg, wait_mode_reg, hold_ext_reg;
    logic strobe_pol_reg, bus_wide_reg, booting_peripheral_reg;
    logic [17:0] io_addr_reg;
    logic [1:0] ram_block_sel_reg, clk_div_reg;
    logic [3:0] bank_select_outputs_n_reg;
    logic [2:0] rd_wait_reg, wr_wait_reg;
    logic [7:0] mf_pin_o_reg, mf_pin_oe_reg, data_hi_in_reg, gpio_in_reg;
    logic [7:0] pg [10] = '{8'h01, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFE, 8'hFF, 8'h00};
    logic [3:0] sel [10] = '{4'hE, 4'hE, 4'hD, 4'hD, 4'hB, 4'hB, 4'h7, 4'h7, 4'hF, 4'hF};
    int errors = 0;
    int samples_checked = 0;
    // 100 MHz core clock
    always #5 mclk = ~mclk;
    mmd_decoder u_dut (.*);
    mmd_pin_model u_pins (.pin_o(mf_pin_o_reg), .pin_oe(mf_pin_oe_reg), .ext_val(8'h3C), .pin(mf_pin_i));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One write strobe per config port, all sharing index and value
    task automatic wr_cfg(input int s, input logic [1:0] idx, input logic [11:0] val);
        @(posedge mclk);
        page_wr <= (s == 0);
        bound_wr <= (s == 1);
        bank_cfg_wr <= (s == 2);
        space_cfg_wr <= (s == 3);
        {page_idx, bound_idx, bank_cfg_idx, space_cfg_idx} <= {4{idx}};
        {page_val, bound_val, bank_cfg_val, space_cfg_val} <= {val[7:0], val[7:0], val[3:0], val};
        @(posedge mclk);
        {page_wr, bound_wr, bank_cfg_wr, space_cfg_wr} <= 4'h0;
    endtask : wr_cfg
    // Single access; decode outputs are read one edge later
    task automatic acc(input mmd_pkg::mmd_kind_t k, input logic [23:0] v);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_kind <= k;
        {req_imm, req_index, req_offset, req_io_imm} <= {v, v[15:0], v[15:0], v[9:0]};
        @(posedge mclk);
        req_valid <= 1'b0;
        #1;
    endtask : acc
    task automatic final_report();
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        #1 chk("pc", 24'hFFFC00, pc_reg);
        acc(mmd_pkg::MMD_FETCH, 24'h000000);
        chk("fetch", 24'hFFFC00, addr_reg);
        chk("bootrom", 24'h1, {23'h0, boot_rom_sel_reg});
        chk("pcinc", 24'hFFFC01, pc_reg);
        foreach (pg[i]) begin
            wr_cfg(0, mmd_pkg::PG_DATA0, {4'h0, pg[i]});
            acc(mmd_pkg::MMD_DAG0, 24'h009234);
            chk("addr", {pg[i], 16'h9234}, addr_reg);
            chk("bank", {20'h0, sel[i]}, {20'h0, bank_select_outputs_n_reg});
        end
        chk("ram", 24'h2, {22'h0, ram_block_sel_reg});
        wr_cfg(0, mmd_pkg::PG_DATA1, 12'h050);
        acc(mmd_pkg::MMD_DAG1, 24'h000100);
        chk("addr1", 24'h500100, addr_reg);
        // Moved boundary and own wait count on bank 1
        wr_cfg(1, 2'h1, 12'h010);
        wr_cfg(2, 2'h1, 12'h002);
        wr_cfg(3, mmd_pkg::SPACE_EXT, 12'h53D);
        wr_cfg(3, mmd_pkg::SPACE_IO, 12'h800);
        wr_cfg(0, mmd_pkg::PG_DATA0, 12'h010);
        gpio_dir <= 8'h0F;
        gpio_out <= 8'hA5;
        acc(mmd_pkg::MMD_DAG0, 24'h000000);
        chk("bank1", 24'hD, {20'h0, bank_select_outputs_n_reg});
        chk("rdwait", 24'h2, {21'h0, rd_wait_reg});
        chk("wide", 24'h0, {23'h0, bus_wide_reg});
        chk("timing", 24'h49, {16'h0, wr_wait_reg, wait_mode_reg, clk_div_reg, hold_ext_reg, strobe_pol_reg});
        chk("oe", 24'h0F, {16'h0, mf_pin_oe_reg});
        repeat (3) @(posedge mclk);
        #1 chk("gpio", 24'h35, {16'h0, gpio_in_reg});
        for (p = 8'h1F; p < 8'h21; p++) begin
            wr_cfg(0, mmd_pkg::PG_IO, {4'h0, p});
            acc(mmd_pkg::MMD_IO, 24'h0003FF);
            chk("ioaddr", {6'h0, p, 10'h3FF}, {6'h0, io_addr_reg});
            chk("iosel", {23'h0, p == 8'h1F}, {23'h0, io_space_select_n_reg});
            chk("iowide", 24'h1, {23'h0, bus_wide_reg});
            acc(mmd_pkg::MMD_BOOT, {p + 8'hDE, 16'h0});
            chk("boot", {23'h0, p == 8'h20}, {23'h0, boot_space_select_n_reg});
        end
        wr_cfg(0, mmd_pkg::PG_DATA0, 12'h0FF);
        rom_protect <= 1'b1;
        req_emu <= 1'b1;
        acc(mmd_pkg::MMD_DAG0, 24'h000100);
        chk("refuse", 24'h1, {23'h0, emu_refused_reg});
        wr_cfg(0, mmd_pkg::PG_JUMP, 12'h077);
        req_emu <= 1'b0;
        acc(mmd_pkg::MMD_DAG0, 24'h000100);
        chk("rom", 24'h1, {23'h0, rom_sel_reg});
        chk("rom_emu", 24'h0, {23'h0, emu_refused_reg});
        acc(mmd_pkg::MMD_SEQ_DIRECT, 24'h123456);
        acc(mmd_pkg::MMD_SEQ_REL, 24'h00FFFE);
        chk("rel", 24'h123454, pc_reg);
        acc(mmd_pkg::MMD_SEQ_INDIRECT, 24'h004321);
        chk("ind", 24'h774321, pc_reg);
        wr_cfg(3, mmd_pkg::SPACE_EXT, 12'hFFF);
        wr_drive <= 1'b1;
        wr_data_hi <= 8'h5A;
        peripheral_boot <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("hi", 24'hFF5A, {8'h0, mf_pin_oe_reg, mf_pin_o_reg});
        chk("hi_in", 24'h005A, {8'h0, gpio_in_reg, data_hi_in_reg});
        chk("pboot", 24'h1, {23'h0, booting_peripheral_reg});
        final_report();
    end
endmodule : mmd_decoder_tb
bind mmd_decoder mmd_chk u_chk (.*);

// [verification/mmd_pin_model.sv]
// Far-side device sharing the multifunction pins
`timescale 1ns/1ns
module mmd_pin_model (
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_val,
    output logic [7:0]     pin
);
    // pin level resolve
    // Bits the decoder leaves undriven carry the peripheral's own level
    assign pin = (pin_o & pin_oe) | (ext_val & ~pin_oe);
endmodule : mmd_pin_model
